/* logic/oec_consts.svh */
// Purpose: constants for the output enable control block
// Assumes: 50 MHz clock, register port with one-cycle read latency
// Notes: offsets are word indices on the plain register port
`ifndef OEC_CONSTS_SVH
`define OEC_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OEC_A_CMD 4'h0
`define OEC_A_STATE 4'h1
`define OEC_A_PINCFG 4'h2
`define OEC_A_LOAD 4'h3
`define OEC_A_VSET 4'h4
`define OEC_A_ISET 4'h5
`define OEC_A_SAVE 4'h6
`define OEC_A_SAVED 4'h7
`define OEC_A_MODE 4'h8
`define OEC_A_VWORK 4'h9
`define OEC_A_IWORK 4'ha
`define OEC_A_VPROT 4'hb
`define OEC_A_IPROT 4'hc

// ****************************************************************
// Field positions
// ****************************************************************
`define OEC_CMD_ON 0
`define OEC_CMD_OFF 1
`define OEC_SAVE_INT 0
`define OEC_SAVE_LOAD 1
`define OEC_SAVE_PWRUP 2

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define OEC_PIN_HON 3'h0
`define OEC_PIN_LON 3'h1
`define OEC_PIN_HIGH_DISABLES_LOW_PERMITS 3'h2
`define OEC_PIN_LOW_DISABLES_HIGH_PERMITS 3'h3
`define OEC_PIN_LOW_PULSE_LATCHED_OFF 3'h4
`define OEC_PIN_NONE 3'h5
`define OEC_LOAD_ACT 2'h0
`define OEC_LOAD_RES 2'h1
`define OEC_LOAD_BATT 2'h2
`define OEC_PROT_LOW 16'h0010
`define OEC_PROT_MAX 16'hffff

// ****************************************************************
// Timing
// ****************************************************************
`define OEC_CLK_MHZ 50
`define OEC_LATCH_US 100
`define OEC_LATCH_CYC (`OEC_LATCH_US * `OEC_CLK_MHZ)

`endif

/* logic/oec_pkg.sv */
// Purpose: types for the output enable control block
// Assumes: constants come from oec_consts.svh
// Notes: all state is held in packed structs
package oec_pkg;

  typedef enum logic [1:0] {
    OEC_ST_IDLE,
    OEC_ST_SAVE,
    OEC_ST_ZERO
  } oec_phase_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } oec_bus_t;

  typedef struct packed {
    logic [15:0] vset;
    logic [15:0] iset;
    logic [15:0] vprot;
    logic [15:0] iprot;
  } oec_setp_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
  } oec_sync_t;

endpackage

/* logic/oec_sync.sv */
// Purpose: two flip-flop synchroniser for the remote on/off pin
// Assumes: pin is asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module oec_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  import oec_pkg::*;

  oec_sync_t st_ff;
  oec_sync_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.sync1 = din;
      nxt_st.sync2 = st_ff.sync1;
    end
  end

  // Idle pin reads as open (logic 1)
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '{sync1: 1'b1, sync2: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.sync2;
endmodule
`default_nettype wire

/* logic/oec_top.sv */
// Purpose: output enable command interpreter with remote on/off pin
// Assumes: register port; pin is asynchronous; single 50 MHz clock
// Notes: setpoints are raw 16-bit codes
`timescale 1ns/1ps
`default_nettype none
`include "oec_consts.svh"

// Operation
// - Output command bit 0/1 turns output on or off.
// - Reset starts local mode with output on; power-up default configurable (reset ignores pwrup_saved and always turns output on).
// - Entering remote mode leaves output state untouched.
// - Off with passive load saves setpoints; voltage source zeros voltage, lowers current limit.
// - Current source off zeros current and lowers voltage limit after saving.
// - On restores setpoints saved at last off.
// - While off, voltage and current setpoint reads return the saved values.
// - State read returns 0 when disabled, 1 when enabled.
// - Pin setting defaults high-disables; kept only after interface save (reset always reloads high-disables; pin_saved is only read back).
// - High-enables: pin high forces on, low forces off.
// - Low-enables: pin low forces on, high forces off.
// - High-disables: pin high holds off; low permits commands.
// - Low-disables: pin low holds off; high permits commands.
// - Latched-off: low for 100 us turns off; only on-command re-enables.
// - Disabled setting ignores the pin entirely.
// - Level-enable settings ignore standby key and on/off commands.
// - Pin setting read returns the selected setting.
// - Load type selects off behaviour; kept only after load-type save (reset always reloads OEC_LOAD_RES; load_saved is only read back).
module oec_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire oec_pkg::oec_bus_t bus,
  input wire logic remote_mode,
  input wire logic standby_key,
  input wire logic remote_onoff_pin,
  output logic [15:0] rdata,
  output logic output_enable,
  output oec_pkg::oec_setp_t working
);
  import oec_pkg::*;

  typedef struct packed {
    logic [15:0] rdata;
    logic out_on;
    logic cur_mode;
    logic [2:0] pin_cfg;
    logic [2:0] pin_saved;
    logic [1:0] load_type;
    logic [1:0] load_saved;
    logic pwrup_on;
    logic pwrup_saved;
    logic latched_off;
    logic [12:0] low_cnt;
    logic remote_ff;
    logic key_prev;
    logic [1:0] prime;
    oec_phase_t phase;
    oec_setp_t prog;
    oec_setp_t saved;
    oec_setp_t work;
  } oec_state_t;

  oec_state_t st_ff;
  oec_state_t nxt_st;
  logic pin_s;

  localparam logic [12:0] LATCH_CYC = 13'(`OEC_LATCH_CYC);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  // two-flop sync
  oec_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .din(remote_onoff_pin),
    .dout(pin_s)
  );

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic level_ctl(input logic [2:0] cfg);
    level_ctl = (cfg == `OEC_PIN_HON) || (cfg == `OEC_PIN_LON);
  endfunction

  function automatic logic wr_hit(input oec_bus_t b, input logic [3:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction

  function automatic logic [2:0] cfg_ok(input logic [2:0] v,
                                        input logic [2:0] old);
    cfg_ok = (v > `OEC_PIN_NONE) ? old : v;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic want_on;
    logic want_off;
    logic hold_off;
    logic cmd_on;
    logic cmd_off;
    logic key_edge;
    logic pin_ok;
    want_on = 1'b0;
    want_off = 1'b0;
    hold_off = 1'b0;
    cmd_on = 1'b0;
    cmd_off = 1'b0;
    key_edge = 1'b0;
    pin_ok = 1'b0;
    nxt_st = st_ff;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    key_edge = standby_key && !st_ff.key_prev;
    cmd_on = wr_hit(bus, `OEC_A_CMD) && bus.wdata[`OEC_CMD_ON];
    cmd_off = wr_hit(bus, `OEC_A_CMD) && bus.wdata[`OEC_CMD_OFF]
              && !bus.wdata[`OEC_CMD_ON];
    // Panel key toggles the output once local mode has held a cycle
    if (key_edge && !remote_mode && !st_ff.remote_ff) begin
      if (st_ff.out_on) begin
        cmd_off = 1'b1;
      end else begin
        cmd_on = 1'b1;
      end
    end

    if (ce) begin
      nxt_st.remote_ff = remote_mode;
      nxt_st.key_prev = standby_key;
      nxt_st.rdata = 16'h0000;
      // both sync stages start at the open level after reset, so
      // the pin decode waits until they hold real samples
      if (st_ff.prime != 2'h2) begin
        nxt_st.prime = st_ff.prime + 2'h1;
      end
      pin_ok = (st_ff.prime == 2'h2);

      // ****************************************************************
      // Pin decode
      // ****************************************************************
      // latched-off counter
      if (st_ff.pin_cfg == `OEC_PIN_LOW_PULSE_LATCHED_OFF && !pin_s && pin_ok) begin
        if (st_ff.low_cnt < LATCH_CYC) begin
          nxt_st.low_cnt = st_ff.low_cnt + 13'h0001;
        end
      end else begin
        nxt_st.low_cnt = 13'h0000;
      end
      if (st_ff.low_cnt >= LATCH_CYC - 13'h0001
          && st_ff.pin_cfg == `OEC_PIN_LOW_PULSE_LATCHED_OFF && !pin_s) begin
        nxt_st.latched_off = 1'b1;
      end else if (cmd_on) begin
        nxt_st.latched_off = 1'b0;
      end

      case (st_ff.pin_cfg)
        `OEC_PIN_HON: begin
          want_on = pin_s;
          want_off = !pin_s;
        end
        `OEC_PIN_LON: begin
          want_on = !pin_s;
          want_off = pin_s;
        end
        `OEC_PIN_HIGH_DISABLES_LOW_PERMITS: hold_off = pin_s;
        `OEC_PIN_LOW_DISABLES_HIGH_PERMITS: hold_off = !pin_s;
        `OEC_PIN_LOW_PULSE_LATCHED_OFF: hold_off = st_ff.latched_off && !cmd_on;
        default: hold_off = 1'b0;
      endcase
      // Until the sync is primed the pin has no say at all
      if (!pin_ok) begin
        want_on = 1'b0;
        want_off = 1'b0;
        hold_off = 1'b0;
      end

      // ****************************************************************
      // Command gating
      // ****************************************************************
      // commands ignored under level control
      if (level_ctl(st_ff.pin_cfg)) begin
        cmd_on = 1'b0;
        cmd_off = 1'b0;
      end
      if (hold_off) begin
        cmd_on = 1'b0;
        cmd_off = st_ff.out_on;
      end
      if (want_on && !st_ff.out_on) begin
        cmd_on = 1'b1;
      end
      if (want_off && st_ff.out_on) begin
        cmd_off = 1'b1;
      end

      // ****************************************************************
      // Register writes
      // ****************************************************************
      // Setpoint writes land in the programmed set
      if (wr_hit(bus, `OEC_A_VSET)) nxt_st.prog.vset = bus.wdata;
      if (wr_hit(bus, `OEC_A_ISET)) nxt_st.prog.iset = bus.wdata;
      if (wr_hit(bus, `OEC_A_VPROT)) nxt_st.prog.vprot = bus.wdata;
      if (wr_hit(bus, `OEC_A_IPROT)) nxt_st.prog.iprot = bus.wdata;
      if (wr_hit(bus, `OEC_A_MODE)) nxt_st.cur_mode = bus.wdata[0];
      if (wr_hit(bus, `OEC_A_PINCFG)) begin
        nxt_st.pin_cfg = cfg_ok(bus.wdata[2:0], st_ff.pin_cfg);
      end
      if (wr_hit(bus, `OEC_A_LOAD) && bus.wdata[1:0] != 2'h3) begin
        nxt_st.load_type = bus.wdata[1:0];
      end
      if (wr_hit(bus, `OEC_A_SAVE)) begin
        if (bus.wdata[`OEC_SAVE_INT]) nxt_st.pin_saved = st_ff.pin_cfg;
        if (bus.wdata[`OEC_SAVE_LOAD]) nxt_st.load_saved = st_ff.load_type;
        if (bus.wdata[`OEC_SAVE_PWRUP]) nxt_st.pwrup_saved = st_ff.pwrup_on;
      end
      if (wr_hit(bus, `OEC_A_STATE)) nxt_st.pwrup_on = bus.wdata[0];

      // Working values follow programmed ones while on
      if (st_ff.out_on) begin
        nxt_st.work = nxt_st.prog;
      end

      // ****************************************************************
      // Off and on sequence
      // ****************************************************************
      // Commands met during the save and zero steps are dropped
      case (st_ff.phase)
        OEC_ST_IDLE: begin
          if (cmd_off && st_ff.out_on) begin
            nxt_st.out_on = 1'b0;
            if (st_ff.load_type != `OEC_LOAD_ACT) begin
              nxt_st.phase = OEC_ST_SAVE;
            end
          end else if (cmd_on && !st_ff.out_on) begin
            nxt_st.out_on = 1'b1;
            nxt_st.prog = st_ff.saved;
            nxt_st.work = st_ff.saved;
          end
        end
        OEC_ST_SAVE: begin
          nxt_st.saved = st_ff.prog;
          nxt_st.phase = OEC_ST_ZERO;
        end
        OEC_ST_ZERO: begin
          nxt_st.work = st_ff.saved;
          if (st_ff.cur_mode) begin
            nxt_st.work.iset = 16'h0000;
            nxt_st.work.vprot = `OEC_PROT_LOW;
          end else begin
            nxt_st.work.vset = 16'h0000;
            nxt_st.work.iprot = `OEC_PROT_LOW;
          end
          nxt_st.phase = OEC_ST_IDLE;
        end
        default: nxt_st.phase = OEC_ST_IDLE;
      endcase
      // Active load: keep current programmed set as the restore point
      if (st_ff.load_type == `OEC_LOAD_ACT && st_ff.phase == OEC_ST_IDLE
          && cmd_off && st_ff.out_on) begin
        nxt_st.saved = st_ff.prog;
      end

      // ****************************************************************
      // Read port
      // ****************************************************************
      if (bus.rd) begin
        case (bus.addr)
          `OEC_A_STATE: nxt_st.rdata = {15'h0000, st_ff.out_on};
          `OEC_A_PINCFG: nxt_st.rdata = {13'h0000, st_ff.pin_cfg};
          `OEC_A_LOAD: nxt_st.rdata = {14'h0000, st_ff.load_type};
          `OEC_A_VSET: nxt_st.rdata = st_ff.out_on ? st_ff.prog.vset
                                                  : st_ff.saved.vset;
          `OEC_A_ISET: nxt_st.rdata = st_ff.out_on ? st_ff.prog.iset
                                                  : st_ff.saved.iset;
          `OEC_A_SAVED: nxt_st.rdata = {9'h000, st_ff.pwrup_saved,
                                        st_ff.load_saved, st_ff.pin_saved,
                                        st_ff.latched_off};
          `OEC_A_MODE: nxt_st.rdata = {15'h0000, st_ff.cur_mode};
          `OEC_A_VWORK: nxt_st.rdata = st_ff.work.vset;
          `OEC_A_IWORK: nxt_st.rdata = st_ff.work.iset;
          `OEC_A_VPROT: nxt_st.rdata = st_ff.prog.vprot;
          `OEC_A_IPROT: nxt_st.rdata = st_ff.prog.iprot;
          default: nxt_st.rdata = 16'h0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // reset defaults
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.out_on <= 1'b1;
      st_ff.pwrup_on <= 1'b1;
      st_ff.pwrup_saved <= 1'b1;
      st_ff.pin_cfg <= `OEC_PIN_HIGH_DISABLES_LOW_PERMITS;
      st_ff.pin_saved <= `OEC_PIN_HIGH_DISABLES_LOW_PERMITS;
      st_ff.load_type <= `OEC_LOAD_RES;
      st_ff.load_saved <= `OEC_LOAD_RES;
      st_ff.prog.vprot <= `OEC_PROT_MAX;
      st_ff.prog.iprot <= `OEC_PROT_MAX;
      st_ff.saved.vprot <= `OEC_PROT_MAX;
      st_ff.saved.iprot <= `OEC_PROT_MAX;
      st_ff.work.vprot <= `OEC_PROT_MAX;
      st_ff.work.iprot <= `OEC_PROT_MAX;
      st_ff.phase <= OEC_ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata = st_ff.rdata;
  assign output_enable = st_ff.out_on;
  assign working = st_ff.work;
endmodule
`default_nettype wire

/* tb/oec_pin_model.sv */
// Purpose: far-side model of the remote on/off pin
// Assumes: the pin has a pull-up, so an open pin reads high
// Notes: the bench picks a driven level or leaves the pin open
`timescale 1ns/1ps
`default_nettype none
module oec_pin_model (
  input wire logic level,
  input wire logic is_open,
  output logic pin
);
  // Open pin is pulled high
  assign pin = is_open ? 1'b1 : level;
endmodule
`default_nettype wire

/* tb/oec_top_sva.sv */
// Purpose: port checker for oec_top
// Assumes: ce held high by the bench
// Notes: pin setting shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "oec_consts.svh"
module oec_top_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire oec_pkg::oec_bus_t bus,
  input wire logic remote_onoff_pin,
  input wire logic [15:0] rdata,
  input wire logic output_enable
);
  import oec_pkg::*;
  logic [2:0] cfg_ff;
  logic [2:0] qt_ff;
  logic pin_ff;
  logic cfg_wr;
  logic pin_quiet;
  assign cfg_wr = bus.wr && bus.addr == `OEC_A_PINCFG;
  // Quiet only once the pin has matched its last sample for 7 edges
  assign pin_quiet = qt_ff == 3'h7 && remote_onoff_pin == pin_ff;
  // ********
  // Pin setting shadow and pin quiet time
  // ********
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_ff <= `OEC_PIN_HIGH_DISABLES_LOW_PERMITS;
      qt_ff <= 3'h0;
      pin_ff <= 1'b1;
    end else if (ce) begin
      pin_ff <= remote_onoff_pin;
      if (cfg_wr && bus.wdata[2:0] < 3'h6) begin
        cfg_ff <= bus.wdata[2:0];
      end
      if (cfg_wr || remote_onoff_pin != pin_ff) begin
        qt_ff <= 3'h0;
      end else if (qt_ff != 3'h7) begin
        qt_ff <= qt_ff + 3'h1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_on_cmd;
    bus.wr && bus.addr == `OEC_A_CMD && bus.wdata[0];
  endsequence
  sequence s_off_cmd;
    bus.wr && bus.addr == `OEC_A_CMD && bus.wdata[1:0] == 2'h2;
  endsequence
  a_rdata_idle: assert property (
    !$past(bus.rd) |-> rdata == 16'h0) else $error("rdata outside slot");
  a_state_read: assert property (
    bus.rd && bus.addr == `OEC_A_STATE |=>
    rdata == {15'h0, $past(output_enable)}) else $error("state read");
  a_cfg_read: assert property (
    bus.rd && bus.addr == `OEC_A_PINCFG |=>
    rdata == {13'h0, $past(cfg_ff)})
    else $error("pin setting read");
  a_high_en: assert property (
    pin_quiet && cfg_ff == `OEC_PIN_HON |->
    output_enable == remote_onoff_pin) else $error("high enables");
  a_low_en: assert property (
    pin_quiet && cfg_ff == `OEC_PIN_LON |->
    output_enable == !remote_onoff_pin) else $error("low enables");
  a_high_dis: assert property (
    pin_quiet && cfg_ff == `OEC_PIN_HIGH_DISABLES_LOW_PERMITS && remote_onoff_pin |->
    !output_enable) else $error("high disables");
  a_low_dis: assert property (
    pin_quiet && cfg_ff == `OEC_PIN_LOW_DISABLES_HIGH_PERMITS && !remote_onoff_pin |->
    !output_enable) else $error("low disables");
  a_off_cmd: assert property (
    s_off_cmd ##0 cfg_ff > 3'h1 |=> !output_enable) else $error("off cmd");
  a_on_cmd: assert property (
    s_on_cmd ##0 cfg_ff == `OEC_PIN_NONE |=> output_enable)
    else $error("on cmd");
  a_level_hold: assert property (
    bus.wr && bus.addr == `OEC_A_CMD && pin_quiet && cfg_ff < 3'h2
    |=> $stable(output_enable)) else $error("cmd not ignored");
endmodule
bind oec_top oec_top_sva u_sva (.clk(clk), .sys_rst(sys_rst), .ce(ce),
  .bus(bus), .remote_onoff_pin(remote_onoff_pin), .rdata(rdata),
  .output_enable(output_enable));
`default_nettype wire

/* tb/oec_top_tb.sv */
// Purpose: self-checking bench for oec_top
// Assumes: register port master, pin model on the far side
// Notes: expectations follow the pin and command behaviour
`timescale 1ns/1ps
`default_nettype none
`include "oec_consts.svh"
module oec_top_tb;
  import oec_pkg::*;
  logic clk;
  logic sys_rst;
  logic ce;
  oec_bus_t bus;
  logic remote_mode;
  logic standby_key;
  logic lvl;
  logic opn;
  logic pin;
  logic [15:0] rdata;
  logic output_enable;
  oec_setp_t working;
  int num_errors;
  int num_checks;
  oec_pin_model pm (.level(lvl), .is_open(opn), .pin(pin));
  oec_top uut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .bus(bus),
    .remote_mode(remote_mode), .standby_key(standby_key),
    .remote_onoff_pin(pin), .rdata(rdata),
    .output_enable(output_enable), .working(working));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic ochk(input logic e);
    chk("output_enable", {15'h0, e}, {15'h0, output_enable});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= {a, d, 2'b10};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rchk(input string w, input logic [3:0] a,
                      input logic [15:0] e);
    @(posedge clk);
    bus <= {a, 16'h0, 2'b01};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(w, e, rdata);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_setp();
    wr(`OEC_A_MODE, 16'h0);
    wr(`OEC_A_VSET, 16'h1234);
    wr(`OEC_A_ISET, 16'h0567);
    wr(`OEC_A_CMD, 16'h0002);
    idle(4);
    chk("vwork", 16'h0, working.vset);
    chk("iprot", `OEC_PROT_LOW, working.iprot);
    rchk("vset", `OEC_A_VSET, 16'h1234);
    rchk("state", `OEC_A_STATE, 16'h0);
    wr(`OEC_A_CMD, 16'h0001);
    idle(4);
    chk("vwork", 16'h1234, working.vset);
    wr(`OEC_A_MODE, 16'h1);
    wr(`OEC_A_CMD, 16'h0002);
    idle(4);
    chk("iwork", 16'h0, working.iset);
    chk("vprot", `OEC_PROT_LOW, working.vprot);
    wr(`OEC_A_CMD, 16'h0001);
    idle(4);
    chk("iwork", 16'h0567, working.iset);
    wr(`OEC_A_LOAD, 16'h0);
    wr(`OEC_A_ISET, 16'h0);
    wr(`OEC_A_CMD, 16'h0002);
    idle(4);
    chk("vwork", 16'h1234, working.vset);
    rchk("load", `OEC_A_LOAD, 16'h0);
    wr(`OEC_A_LOAD, 16'h1);
    $display("test setpoints done");
  endtask
  task automatic t_pin();
    logic e;
    for (int c = 0; c < 6; c++) begin
      for (int p = 0; p < 2; p++) begin
        if (c == 4) continue;
        wr(`OEC_A_PINCFG, 16'h5);
        lvl <= p[0];
        wr(`OEC_A_CMD, 16'h0001);
        wr(`OEC_A_PINCFG, 16'(c));
        idle(10);
        e = (c == 0 || c == 3) ? p[0] : (c == 5) ? 1'b1 : !p[0];
        ochk(e);
        rchk("pincfg", `OEC_A_PINCFG, 16'(c));
        if (c < 2) begin
          @(posedge clk);
          standby_key <= 1'b1;
          idle(2);
          @(posedge clk);
          standby_key <= 1'b0;
        end
        wr(`OEC_A_CMD, 16'h0002);
        idle(4);
        ochk(c < 2 ? e : 1'b0);
      end
    end
    wr(`OEC_A_PINCFG, 16'h6);
    rchk("pincfg", `OEC_A_PINCFG, 16'h5);
    $display("test pin settings done");
  endtask
  task automatic t_latch();
    @(posedge clk);
    lvl <= 1'b1;
    wr(`OEC_A_CMD, 16'h0001);
    wr(`OEC_A_PINCFG, {13'h0000, `OEC_PIN_LOW_PULSE_LATCHED_OFF});
    lvl <= 1'b0;
    idle(`OEC_LATCH_CYC - 100);
    @(posedge clk);
    lvl <= 1'b1;
    idle(10);
    ochk(1'b1);
    @(posedge clk);
    lvl <= 1'b0;
    idle(`OEC_LATCH_CYC + 100);
    ochk(1'b0);
    @(posedge clk);
    opn <= 1'b1;
    idle(10);
    ochk(1'b0);
    wr(`OEC_A_CMD, 16'h0001);
    idle(4);
    ochk(1'b1);
    @(posedge clk);
    remote_mode <= 1'b1;
    idle(4);
    ochk(1'b1);
    wr(`OEC_A_CMD, 16'h0002);
    idle(4);
    ochk(1'b0);
    $display("test latch and remote done");
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    bus = '0;
    ce = 1'b1;
    remote_mode = 1'b0;
    standby_key = 1'b0;
    lvl = 1'b0;
    opn = 1'b0;
    sys_rst = 1'b1;
    num_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rchk("state", `OEC_A_STATE, 16'h1);
    rchk("pincfg", `OEC_A_PINCFG, 16'h2);
    idle(6);
    ochk(1'b1);
    t_setp();
    t_pin();
    t_latch();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
